// [hdl/eafc_flow_ctrl.sv]
// Notes on behaviour
// - No pause or jam while transmitter off.
// - High level, 64-byte units, triggers flow control.
// - Full duplex: one pause, MAC pause time.
// - Half duplex: jam each matching frame.
// - Below low level: send zero-time pause.
// - Zero pause only after high pause sent.
// - Zero pause whenever any selection bit set.
// - Duration field sets jam; unused full duplex.
// - Duration table; 10 Mb/s adds 2.2 us.
// - Multicast select jams multicast frames.
// - Broadcast select jams broadcast frames.
// - Own-address select jams frames for us.
// - Any-frame select; enables full-duplex control.
// - Any-frame half duplex acts on preamble.
// - Any-frame full duplex requests pause immediately.
// - Any-frame overrides other selection bits.
`timescale 1ns/100ps
module eafc_flow_ctrl #(
  parameter int TICK_CYCLES = eafc_pkg::TICK_CYC
) (
  input  wire logic                         mclk,
  input  wire logic                         srst,
  input  wire logic [7:0]                   paddr,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         txEnable,
  input  wire logic                         fullDuplex,
  input  wire logic                         linkSpeed100,
  input  wire logic [eafc_pkg::FIFO_AW-1:0] rxFifoBytes,
  input  wire logic                         rxPreamble,
  input  wire logic                         rxAddrValid,
  input  wire logic                         rxMulticast,
  input  wire logic                         rxBroadcast,
  input  wire logic                         rxOwnAddress,
  input  wire logic [15:0]                  pause_time_value,
  input  wire logic                         pauseDone,
  output logic                              pauseRequest,
  output logic      [15:0]                  pauseTime,
  output logic                              backpressure
);
  // Configuration word as software wrote it.
  logic [23:0]           cfg;
  // Status byte returned on reads of the status register.
  logic [7:0]            status;
  // Pause sequencer state and its next value.
  eafc_pkg::eafc_state_t state_ff;
  eafc_pkg::eafc_state_t nxt_state;
  // Registered outputs towards the MAC transmitter.
  logic                  pauseReq_ff;
  logic [15:0]           pauseTime_ff;
  logic                  jam_ff;
  // The jam timer runs while back pressure is due.
  logic                  timerBusy;

  // Field extraction from the configuration word.
  wire [7:0] flow_high_threshold = cfg[eafc_pkg::HI_MSB:eafc_pkg::HI_LSB];
  wire [7:0] flow_low_threshold  = cfg[eafc_pkg::LO_MSB:eafc_pkg::LO_LSB];
  wire [3:0] backpressure_length = cfg[eafc_pkg::DUR_MSB:eafc_pkg::DUR_LSB];
  wire       flow_on_multicast   = cfg[eafc_pkg::SEL_MULT];
  wire       flow_on_broadcast   = cfg[eafc_pkg::SEL_BRD];
  wire       flow_on_own_address = cfg[eafc_pkg::SEL_OWN];
  wire       flow_on_any_frame   = cfg[eafc_pkg::SEL_ANY];

  // Thresholds scaled from 64-byte units into bytes.
  wire [eafc_pkg::FIFO_AW-1:0] hiBytes = {flow_high_threshold, {eafc_pkg::UNIT_BITS{1'b0}}};
  wire [eafc_pkg::FIFO_AW-1:0] loBytes = {flow_low_threshold, {eafc_pkg::UNIT_BITS{1'b0}}};

  // Level comparisons against the receive FIFO byte count.
  wire hiReached = (rxFifoBytes >= hiBytes);
  wire belowLo   = (rxFifoBytes < loBytes);

  // Automatic flow control counts as enabled when any selection bit is set.
  wire autoEn = |cfg[eafc_pkg::SEL_MULT:eafc_pkg::SEL_ANY];

  // Only the any-frame bit enables the pause path in full duplex.
  wire fdEnable = txEnable & fullDuplex & flow_on_any_frame;

  // Address-based match; ignored entirely when any-frame is selected.
  wire addrMatch = (rxMulticast & flow_on_multicast)
                 | (rxBroadcast & flow_on_broadcast)
                 | (rxOwnAddress & flow_on_own_address);

  // Any-frame acts on the preamble without waiting for the address.
  wire anyHit = flow_on_any_frame & rxPreamble;
  wire selHit = ~flow_on_any_frame & rxAddrValid & addrMatch;

  // Half duplex jam start for each matching frame above the high level.
  wire jamStart = txEnable & ~fullDuplex & hiReached & (anyHit | selHit);

  // The duration is only consulted in half duplex; the timer is also dropped
  // at once if the transmitter goes off or the link turns full duplex.
  wire jamAbort = ~txEnable | fullDuplex;

  // Decode of the current pause sequencer state.
  wire stIdle = (state_ff == eafc_pkg::ST_IDLE);
  wire stReqH = (state_ff == eafc_pkg::ST_REQH);
  wire stSent = (state_ff == eafc_pkg::ST_SENT);
  wire stReqZ = (state_ff == eafc_pkg::ST_REQZ);

  // The zero-time release is due once the level sinks below the low mark.
  wire zeroDue = txEnable & autoEn & belowLo;

  // Status byte: level flags, sequencer state and live outputs.
  assign status = {state_ff, jam_ff, pauseReq_ff, belowLo, hiReached};

  // Outputs come straight from flops.
  assign pauseRequest = pauseReq_ff;
  assign pauseTime    = pauseTime_ff;
  assign backpressure = jam_ff;

  // Register slave on APB.
  eafc_apb_regs i_eafc_apb_regs (
    .mclk     (mclk),
    .srst     (srst),
    .paddr    (paddr),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .pwdata   (pwdata),
    .statusIn (status),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .cfgOut   (cfg)
  );

  // Jam duration timer, ticking in 0.1 us steps.
  eafc_bp_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) i_eafc_bp_timer (
    .mclk     (mclk),
    .srst     (srst),
    .start    (jamStart),
    .abort    (jamAbort),
    .durCode  (backpressure_length),
    .speed100 (linkSpeed100),
    .busy     (timerBusy)
  );

  // Sequencer: one pause at the high level, then hold in SENT until the
  // zero-time pause goes out. A request withdrawn because the transmitter
  // stopped returns to where it came from, so the sent flag is never lost.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      eafc_pkg::ST_IDLE: begin
        // Request at once when the high level is reached.
        if (fdEnable & hiReached) begin
          nxt_state = eafc_pkg::ST_REQH;
        end
      end
      eafc_pkg::ST_REQH: begin
        // The MAC confirms the frame; only then is it counted as sent.
        if (~txEnable) begin
          nxt_state = eafc_pkg::ST_IDLE;
        end else if (pauseDone) begin
          nxt_state = eafc_pkg::ST_SENT;
        end
      end
      eafc_pkg::ST_SENT: begin
        // Only reachable after a real high-level pause frame.
        if (zeroDue) begin
          nxt_state = eafc_pkg::ST_REQZ;
        end
      end
      eafc_pkg::ST_REQZ: begin
        // Zero-time frame sent clears the sent flag.
        if (~txEnable) begin
          nxt_state = eafc_pkg::ST_SENT;
        end else if (pauseDone) begin
          nxt_state = eafc_pkg::ST_IDLE;
        end
      end
      default: begin
        // A broken one-hot code recovers to idle.
        nxt_state = eafc_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer state register.
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_ff <= eafc_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Pause request and time, held steady for the MAC while a request stands.
  // The high-level time is sampled when the request starts, so a later
  // change to the MAC pause field does not corrupt a frame in the queue.
  always_ff @(posedge mclk) begin
    if (srst) begin
      pauseReq_ff  <= 1'b0;
      pauseTime_ff <= eafc_pkg::ZERO_PAUSE;
    end else begin
      pauseReq_ff <= (nxt_state == eafc_pkg::ST_REQH) | (nxt_state == eafc_pkg::ST_REQZ);
      if (stIdle & (nxt_state == eafc_pkg::ST_REQH)) begin
        pauseTime_ff <= pause_time_value;
      end else if (stSent & (nxt_state == eafc_pkg::ST_REQZ)) begin
        pauseTime_ff <= eafc_pkg::ZERO_PAUSE;
      end
    end
  end

  // Back pressure follows the timer, gated by transmitter and duplex.
  always_ff @(posedge mclk) begin
    if (srst) begin
      jam_ff <= 1'b0;
    end else begin
      jam_ff <= timerBusy & txEnable & ~fullDuplex;
    end
  end

  // Named sequences for the multi-step checks.
  sequence s_hi_done;
    stReqH && txEnable && pauseDone;
  endsequence

  sequence s_jam_go;
    jamStart ##1 (txEnable && !fullDuplex);
  endsequence

  // Zero-time frame confirmed by the MAC while the transmitter is still on.
  sequence s_zero_done;
    stReqZ && txEnable && pauseDone;
  endsequence

  property p_tx_off_quiet;
    @(posedge mclk) disable iff (srst)
    !txEnable |=> (!pauseRequest && !backpressure);
  endproperty
  a_tx_off_quiet: assert property (p_tx_off_quiet) else $error("Pause or jam with tx off.");

  property p_hi_pause;
    @(posedge mclk) disable iff (srst)
    (stIdle && fdEnable && hiReached) |=>
      (pauseRequest && pauseTime == $past(pause_time_value));
  endproperty
  a_hi_pause: assert property (p_hi_pause) else $error("High level pause missing.");

  property p_single_pause;
    @(posedge mclk) disable iff (srst)
    s_hi_done |=> (!pauseRequest && stSent);
  endproperty
  a_single_pause: assert property (p_single_pause) else $error("Second high pause sent.");

  property p_zero_after_sent;
    @(posedge mclk) disable iff (srst)
    $rose(stReqZ) |-> $past(stSent);
  endproperty
  a_zero_after_sent: assert property (p_zero_after_sent) else $error("Zero pause unearned.");

  property p_lo_release;
    @(posedge mclk) disable iff (srst)
    (stSent && zeroDue) |=> (pauseRequest && pauseTime == eafc_pkg::ZERO_PAUSE);
  endproperty
  a_lo_release: assert property (p_lo_release) else $error("Zero pause not requested.");

  property p_fd_no_jam;
    @(posedge mclk) disable iff (srst)
    fullDuplex |=> !backpressure;
  endproperty
  a_fd_no_jam: assert property (p_fd_no_jam) else $error("Jam in full duplex.");

  property p_jam_starts;
    @(posedge mclk) disable iff (srst)
    s_jam_go |=> backpressure;
  endproperty
  a_jam_starts: assert property (p_jam_starts) else $error("Frame not jammed.");

  property p_any_on_preamble;
    @(posedge mclk) disable iff (srst)
    (flow_on_any_frame && rxPreamble && hiReached && txEnable && !fullDuplex)
      |=> timerBusy;
  endproperty
  a_any_on_preamble: assert property (p_any_on_preamble) else $error("Preamble ignored.");

  property p_no_high_no_jam;
    @(posedge mclk) disable iff (srst)
    (!timerBusy && !hiReached) |=> !timerBusy;
  endproperty
  a_no_high_no_jam: assert property (p_no_high_no_jam) else $error("Jam below level.");

  // Once the zero-time frame is out, the sent flag clears for a new round.
  property p_zero_clears;
    @(posedge mclk) disable iff (srst)
    s_zero_done |=> (!pauseRequest && stIdle);
  endproperty
  a_zero_clears: assert property (p_zero_clears) else $error("Sent flag kept.");

  // A queued request stays up, its time frozen, until the MAC answers.
  // Dropping it early would lose the frame while the wire is busy.
  property p_req_holds;
    @(posedge mclk) disable iff (srst)
    (pauseRequest && txEnable && !pauseDone) |=>
      (pauseRequest && $stable(pauseTime));
  endproperty
  a_req_holds: assert property (p_req_holds) else $error("Request dropped early.");

  // The zero-time release needs automatic control on and the level low.
  property p_zero_cause;
    @(posedge mclk) disable iff (srst)
    $rose(stReqZ) |-> $past(autoEn && belowLo && txEnable);
  endproperty
  a_zero_cause: assert property (p_zero_cause) else $error("Zero pause uncaused.");

  // Without the any-frame bit the full-duplex pause path stays asleep.
  property p_any_gates_fd;
    @(posedge mclk) disable iff (srst)
    (stIdle && !flow_on_any_frame) |=> !pauseRequest;
  endproperty
  a_any_gates_fd: assert property (p_any_gates_fd) else $error("Pause not enabled.");

  // Half duplex answers with a jam only; a new pause round never starts.
  property p_hd_no_pause;
    @(posedge mclk) disable iff (srst)
    (stIdle && !fullDuplex) |=> !pauseRequest;
  endproperty
  a_hd_no_pause: assert property (p_hd_no_pause) else $error("Pause in half duplex.");

  // With any-frame set, an address event alone must not start a jam.
  property p_any_overrides;
    @(posedge mclk) disable iff (srst)
    (flow_on_any_frame && !rxPreamble && !timerBusy) |=> !timerBusy;
  endproperty
  a_any_overrides: assert property (p_any_overrides) else $error("Override lost.");

  // A class-selected frame above the high level starts the jam timer.
  // One check covers all three class bits, since they share the match term.
  property p_class_jam;
    @(posedge mclk) disable iff (srst)
    (!flow_on_any_frame && rxAddrValid && addrMatch && hiReached
      && txEnable && !fullDuplex) |=> timerBusy;
  endproperty
  a_class_jam: assert property (p_class_jam) else $error("Class frame not jammed.");

  // Transmitter off or full duplex stops a running jam at the next edge.
  property p_jam_abort;
    @(posedge mclk) disable iff (srst)
    jamAbort |=> !timerBusy;
  endproperty
  a_jam_abort: assert property (p_jam_abort) else $error("Jam not stopped.");
endmodule

// [hdl/eafc_pkg.sv]
package eafc_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [7:0]  CFG_OFS     = 8'hAC;
  localparam logic [7:0]  STAT_OFS    = 8'hFC;
  // Configuration field positions.
  localparam int          HI_MSB      = 23;
  localparam int          HI_LSB      = 16;
  localparam int          LO_MSB      = 15;
  localparam int          LO_LSB      = 8;
  localparam int          DUR_MSB     = 7;
  localparam int          DUR_LSB     = 4;
  localparam int          SEL_MULT    = 3;
  localparam int          SEL_BRD     = 2;
  localparam int          SEL_OWN     = 1;
  localparam int          SEL_ANY     = 0;
  localparam int          CFG_W       = 24;
  localparam logic [23:0] CFG_RESET   = 24'h000000;
  // Thresholds are in 64-byte units; the FIFO byte count is 14 bits wide.
  localparam int          UNIT_BITS   = 6;
  localparam int          FIFO_AW     = 14;
  // Clock period and duration tick, in nanoseconds.
  localparam int          CLK_NS      = 4;
  localparam int          TICK_NS     = 100;
  localparam int          TICK_CYC    = TICK_NS / CLK_NS;
  // Jam durations in 0.1 us ticks at 100 Mb/s, and the 10 Mb/s extra.
  localparam int          DUR_W       = 13;
  localparam logic [12:0] DUR_TBL [16] = '{
    13'h0032, 13'h0064, 13'h0096, 13'h00FA, 13'h01F4, 13'h03E8, 13'h05DC, 13'h07D0,
    13'h09C4, 13'h0BB8, 13'h0DAC, 13'h0FA0, 13'h1194, 13'h1388, 13'h157C, 13'h1770};
  localparam logic [12:0] DUR_10M_ADD = 13'h0016;
  localparam logic [15:0] ZERO_PAUSE  = 16'h0000;
  // Pause sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_REQH = 4'b0010,
    ST_SENT = 4'b0100,
    ST_REQZ = 4'b1000
  } eafc_state_t;
endpackage

// [hdl/eafc_apb_regs.sv]
`timescale 1ns/100ps
module eafc_apb_regs (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [7:0]  statusIn,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [23:0] cfgOut
);
  logic [23:0] cfg_ff;     // Configuration word; bits 31:24 are reserved.
  logic [31:0] prdata_ff;  // Registered read data.
  logic        pready_ff;  // One wait state, then ready.
  logic        pslverr_ff; // Error on unmapped address.

  // Address decode and read selection.
  wire         hitCfg  = (paddr == eafc_pkg::CFG_OFS);
  wire         hitStat = (paddr == eafc_pkg::STAT_OFS);
  wire         access  = psel & penable;
  wire         wrDone  = access & pready_ff & pwrite & hitCfg;
  wire  [31:0] rdMux   = hitCfg  ? {8'h00, cfg_ff} :
                         hitStat ? {24'h000000, statusIn} : 32'h00000000;

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign cfgOut  = cfg_ff;

  // The answer is formed in the first access cycle so that every output is a
  // flop; this costs one wait state but keeps the decode off the bus outputs.
  always_ff @(posedge mclk) begin
    if (srst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else begin
      pready_ff  <= access & ~pready_ff;
      pslverr_ff <= access & ~pready_ff & ~(hitCfg | hitStat);
      prdata_ff  <= (access & ~pready_ff & ~pwrite) ? rdMux : 32'h00000000;
    end
  end

  // Writes land only at the edge where the master sees pready high.
  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg_ff <= eafc_pkg::CFG_RESET;
    end else if (wrDone) begin
      cfg_ff <= pwdata[23:0];
    end
  end
endmodule

// [hdl/eafc_bp_timer.sv]
`timescale 1ns/100ps
module eafc_bp_timer #(
  parameter int TICK_CYCLES = eafc_pkg::TICK_CYC
) (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic [3:0] durCode,
  input  wire logic       speed100,
  output logic            busy
);
  logic [15:0]                  div_ff;  // Divider towards the 0.1 us tick.
  logic [eafc_pkg::DUR_W-1:0]   left_ff; // Ticks of jam still to run.
  logic                         busy_ff; // Jam period running.

  // At 10 Mb/s every duration is 2.2 us longer.
  wire [eafc_pkg::DUR_W-1:0] durLoad = eafc_pkg::DUR_TBL[durCode] +
                                       (speed100 ? '0 : eafc_pkg::DUR_10M_ADD);
  wire tick = busy_ff & (div_ff == 16'(TICK_CYCLES - 1));
  wire last = tick & (left_ff == 13'h0001);

  assign busy = busy_ff;

  // A new start restarts the period, so each matching frame is jammed fully.
  always_ff @(posedge mclk) begin
    if (srst | abort) begin
      busy_ff <= 1'b0;
      div_ff  <= 16'h0000;
      left_ff <= '0;
    end else if (start) begin
      busy_ff <= 1'b1;
      div_ff  <= 16'h0000;
      left_ff <= durLoad;
    end else if (busy_ff) begin
      div_ff  <= tick ? 16'h0000 : div_ff + 16'h0001;
      left_ff <= tick ? left_ff - 13'h0001 : left_ff;
      busy_ff <= ~last;
    end
  end
endmodule

// [tb/eafc_mac_model.sv]
`timescale 1ns/100ps
// Behavioural MAC transmitter that answers each pause request with a one-cycle done pulse.
module eafc_mac_model #(
  parameter int LAT = 6
) (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic stall,
  input  wire logic pauseRequest,
  output logic      pauseDone
);
  int   cnt_ff;   // Unstalled cycles the pending request has spent in a transmit window.
  logic done_ff;  // Done pulse register.

  assign pauseDone = done_ff;

  // The done pulse only comes while a request stands, never unprompted.
  // A stall models a wire busy with a long frame, so the request must be held.
  always_ff @(posedge mclk) begin
    if (srst || !pauseRequest || done_ff) begin
      cnt_ff  <= 0;
      done_ff <= 1'h0;
    end else if (!stall) begin
      cnt_ff  <= cnt_ff + 1;
      done_ff <= (cnt_ff == LAT - 1);
    end
  end
endmodule

// [tb/ethernet_auto_flow_control_test.sv]
`timescale 1ns/100ps
// Self-checking bench for the automatic flow controller.
module ethernet_auto_flow_control_test;
  localparam int          TC = 2;            // Short tick so that jams stay brief.
  localparam logic [15:0] PT = 16'h1234;     // Pause time offered by the MAC.
  logic                                mclk         = 1'h0;
  logic                                srst         = 1'h1;
  logic [7:0]                          paddr        = 8'h00;
  logic                                psel         = 1'h0;
  logic                                penable      = 1'h0;
  logic                                pwrite       = 1'h0;
  logic [31:0]                         pwdata       = 32'h00000000;
  logic                                txEnable     = 1'h1;
  logic                                fullDuplex   = 1'h1;
  logic                                linkSpeed100 = 1'h1;
  logic [eafc_pkg::FIFO_AW-1:0]        rxFifoBytes  = 14'h0000;
  logic [4:0]                          rxEv         = 5'h00;  // Preamble, addr, mc, bc, own.
  logic                                stall        = 1'h0;
  logic [31:0]                         prdata;
  logic                                pready;
  logic                                pslverr;
  logic                                pauseDone;
  logic                                pauseRequest;
  logic [15:0]                         pauseTime;
  logic                                backpressure;
  logic [31:0]                         rd;
  logic                                err;
  int                                  fail_count   = 0;
  int                                  num_checks   = 0;
  int                                  a;

  // Free-running 250 MHz clock.
  always #2 mclk = ~mclk;

  eafc_flow_ctrl #(.TICK_CYCLES(TC)) i_eafc_flow_ctrl (
    .mclk(mclk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .txEnable(txEnable), .fullDuplex(fullDuplex), .linkSpeed100(linkSpeed100),
    .rxFifoBytes(rxFifoBytes), .rxPreamble(rxEv[4]), .rxAddrValid(rxEv[3]),
    .rxMulticast(rxEv[2]), .rxBroadcast(rxEv[1]), .rxOwnAddress(rxEv[0]),
    .pause_time_value(PT), .pauseDone(pauseDone), .pauseRequest(pauseRequest),
    .pauseTime(pauseTime), .backpressure(backpressure));

  eafc_mac_model i_eafc_mac_model (
    .mclk(mclk), .srst(srst), .stall(stall), .pauseRequest(pauseRequest),
    .pauseDone(pauseDone));

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    chk(n, 2, "apb wait states");
    // One idle edge so no strobe is driven twice in one step.
    @(posedge mclk);
  endtask

  task automatic rdchk(input logic [7:0] ad, input logic [31:0] e, input logic ee);
    apb(1'h0, ad, 32'h00000000);
    chk(rd, e, "read data");
    chk(err, ee, "slave error");
  endtask

  // Waits for the pause request to reach a level within mx edges.
  task automatic waitPr(input logic lvl, input int mx);
    int n;
    n = 0;
    while (pauseRequest !== lvl && n <= mx) begin
      @(posedge mclk);
      n++;
    end
    chk(n <= mx, 1'h1, "pause request timing");
  endtask

  // Watches n cycles in which neither pause nor jam may appear.
  task automatic quiet(input int n);
    int s;
    s = 0;
    repeat (n) begin
      @(posedge mclk);
      s += (pauseRequest !== 1'h0) + (backpressure !== 1'h0);
    end
    chk(s, 0, "unexpected pause or jam");
  endtask

  // Presents one receive event for a single cycle.
  task automatic pulse(input logic [4:0] v);
    rxEv <= v;
    @(posedge mclk);
    rxEv <= 5'h00;
  endtask

  // Jam length in ticks at 100 Mb/s, with the 10 Mb/s extra when slow.
  function automatic int ticks(input int c, input logic fast);
    int t[5] = '{50, 100, 150, 250, 500};
    ticks = (c < 5 ? t[c] : (c - 3) * 500) + (fast ? 0 : 22);
  endfunction

  // Measures the jam following an event; the tick phase allows a small slack.
  task automatic jam(input int tk);
    int dly;
    int len;
    dly = 0;
    len = 0;
    do begin
      @(posedge mclk);
      dly++;
    end while (backpressure !== 1'h1 && dly < 10);
    while (backpressure === 1'h1 && len < 20000) begin
      @(posedge mclk);
      len++;
    end
    chk(dly, 2, "jam delay");
    chk(len > tk * TC - 3 * TC && len < tk * TC + 3 * TC, 1'h1, "jam length");
  endtask

  task automatic done(input string m);
    $display("test %s finished", m);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // The whole sequence needs under 8000 cycles; this limit leaves ample margin.
  initial begin
    repeat (30000) @(posedge mclk);
    fail_count++;
    summarize();
  end

  initial begin
    repeat (20) @(posedge mclk);
    srst <= 1'h0;
    @(posedge mclk);
    rdchk(eafc_pkg::CFG_OFS, 32'h00000000, 1'h0);
    rdchk(eafc_pkg::STAT_OFS, 32'h00000011, 1'h0);
    apb(1'h1, eafc_pkg::CFG_OFS, 32'hFF040231);
    apb(1'h1, 8'h00, 32'hFFFFFFFF);
    rdchk(eafc_pkg::CFG_OFS, 32'h00040231, 1'h0);
    rdchk(8'h00, 32'h00000000, 1'h1);
    done("registers");
    apb(1'h1, eafc_pkg::CFG_OFS, 32'h00040201);
    rxFifoBytes <= 14'h00FF;
    quiet(20);
    rxFifoBytes <= 14'h0100;
    waitPr(1'h1, 3);
    chk(pauseTime, PT, "high pause time");
    waitPr(1'h0, 20);
    quiet(40);
    rdchk(eafc_pkg::STAT_OFS, 32'h00000041, 1'h0);
    rxFifoBytes <= 14'h0080;
    quiet(20);
    rxFifoBytes <= 14'h007F;
    waitPr(1'h1, 3);
    chk(pauseTime, 16'h0000, "zero pause time");
    waitPr(1'h0, 20);
    quiet(20);
    done("full duplex pause");
    stall <= 1'h1;
    rxFifoBytes <= 14'h012C;
    waitPr(1'h1, 3);
    repeat (30) @(posedge mclk);
    chk(pauseRequest, 1'h1, "request held");
    txEnable <= 1'h0;
    waitPr(1'h0, 2);
    quiet(20);
    txEnable <= 1'h1;
    stall <= 1'h0;
    waitPr(1'h1, 3);
    waitPr(1'h0, 20);
    rxFifoBytes <= 14'h0000;
    waitPr(1'h1, 3);
    chk(pauseTime, 16'h0000, "zero pause time");
    waitPr(1'h0, 20);
    apb(1'h1, eafc_pkg::CFG_OFS, 32'h0004020E);
    rxFifoBytes <= 14'h012C;
    pulse(5'h0F);
    quiet(30);
    done("transmitter off and selection");
    fullDuplex <= 1'h0;
    // Codes 0 to 5 at 100 Mb/s, then code 0 at 10 Mb/s.
    for (a = 0; a < 7; a++) begin
      apb(1'h1, eafc_pkg::CFG_OFS, 32'h00040201 | 32'((a % 6) << 4));
      linkSpeed100 <= (a < 6);
      pulse(5'h10);
      jam(ticks(a % 6, a < 6));
    end
    linkSpeed100 <= 1'h1;
    rxFifoBytes <= 14'h00FF;
    pulse(5'h10);
    quiet(20);
    rxFifoBytes <= 14'h012C;
    pulse(5'h10);
    repeat (5) @(posedge mclk);
    txEnable <= 1'h0;
    repeat (2) @(posedge mclk);
    chk(backpressure, 1'h0, "jam abort");
    pulse(5'h10);
    quiet(20);
    txEnable <= 1'h1;
    done("half duplex jam");
    // Each class bit alone: other classes and a bare preamble are ignored.
    for (a = 1; a < 4; a++) begin
      apb(1'h1, eafc_pkg::CFG_OFS, 32'h00040200 | 32'(1 << a));
      pulse(5'h18 | (5'h07 & ~5'(1 << (a - 1))));
      quiet(20);
      pulse(5'h08 | 5'(1 << (a - 1)));
      jam(ticks(0, 1'h1));
    end
    apb(1'h1, eafc_pkg::CFG_OFS, 32'h00040209);
    pulse(5'h0C);
    quiet(20);
    pulse(5'h10);
    jam(ticks(0, 1'h1));
    done("frame classes");
    summarize();
  end
endmodule
